/* File: verilog/vei_top.sv */
`timescale 1ns/1ps
module vei_top (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Field access instructions
	input wire logic fld_wr_i,
	input wire logic fld_rd_i,
	input wire logic [3:0] fld_sel_i,
	input wire logic [63:0] fld_wdata_i,
	output logic fld_ack_o,
	output logic fld_fail_o,
	output logic [63:0] fld_rdata_o,
	// Guest entry request
	input wire logic entry_start_i,
	input wire logic [63:0] guest_ip_i,
	output logic entry_ready_o,
	output logic entry_done_o,
	output logic entry_fail_o,
	// Load-area memory reads
	output logic mem_req_o,
	output logic [63:0] mem_addr_o,
	input wire logic mem_ack_i,
	input wire logic [127:0] mem_rdata_i,
	// Model-specific register writes
	output logic msr_wr_o,
	output logic [31:0] msr_index_o,
	output logic [63:0] msr_data_o,
	// Event injection to delivery logic
	output logic inj_valid_o,
	output logic [7:0] inj_vector_o,
	output logic [2:0] inj_type_o,
	output logic inj_push_err_o,
	output logic [31:0] inj_err_o,
	output logic [63:0] inj_ip_o,
	// Guest exit report
	input wire logic exit_req_i,
	input wire logic [15:0] exit_basic_i,
	input wire logic exit_entry_fail_i,
	input wire logic exit_root_i,
	input wire logic exit_smm_i,
	input wire logic [63:0] exit_qual_i,
	input wire logic exit_vectored_i,
	input wire logic [2:0] exit_type_i,
	input wire logic [7:0] exit_vector_i,
	input wire logic exit_errv_i,
	input wire logic [31:0] exit_err_i,
	input wire logic exit_unblock_i,
	input wire logic exit_ack_ctl_i,
	output logic exit_ready_o,
	output logic exit_done_o,
	// Interrupt controller acknowledge
	output logic intack_req_o,
	input wire logic intack_ack_i,
	input wire logic [7:0] intack_vector_i
);

	typedef enum logic [2:0] {
		VEI_IDLE = 3'b000,
		VEI_LOAD = 3'b001,
		VEI_INJECT = 3'b010,
		VEI_ACK = 3'b011
	} vei_state_type;

	typedef struct packed {
		vei_state_type st;
		logic [31:0] cnt;
		logic [63:0] addr;
		logic [31:0] einfo;
		logic [31:0] eerr;
		logic [31:0] elen;
		logic [31:0] idx;
		logic mem_req;
		logic [63:0] mem_addr;
		logic msr_wr;
		logic [31:0] msr_index;
		logic [63:0] msr_data;
		logic inj_valid;
		logic [7:0] inj_vec;
		logic [2:0] inj_type;
		logic inj_push;
		logic [31:0] inj_err;
		logic [63:0] inj_ip;
		logic done;
		logic fail;
		logic exit_done;
		logic [31:0] hold_reason;
		logic [63:0] hold_qual;
		logic fld_ack;
		logic fld_fail;
		logic [63:0] fld_rdata;
	} vei_top_type;

	vei_top_type r_r;
	vei_top_type r_nxt;

	vei_exit_if ex ();

	// Exit field storage
	vei_exit_rec u_rec (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.ex(ex.rec)
	);

	// Decoded views of the entry info field, new exit reason and info values, and the read-only select check
	logic [2:0] ent_type;
	logic ent_valid;
	logic ent_type_ok;
	logic ent_sw_type;
	logic [31:0] reason_new;
	logic [31:0] info_new;
	logic vec_record;
	logic fld_is_ro;

	assign ent_type = r_r.einfo[vei_pkg::VEI_INFO_TYPE_MSB:vei_pkg::VEI_INFO_TYPE_LSB];
	assign ent_valid = r_r.einfo[vei_pkg::VEI_INFO_VALID];
	assign ent_type_ok = (ent_type != vei_pkg::VEI_TYP_RSV1) && (ent_type != vei_pkg::VEI_TYP_RSV7);
	assign ent_sw_type = (ent_type == vei_pkg::VEI_TYP_SWINT) || (ent_type == vei_pkg::VEI_TYP_PRIVSW)
		|| (ent_type == vei_pkg::VEI_TYP_SWEXC);

	// Exit reason: reserved bits forced to zero
	always_comb
	begin
		reason_new = 32'h0000_0000;
		reason_new[vei_pkg::VEI_RSN_BASIC_MSB:0] = exit_basic_i;
		reason_new[vei_pkg::VEI_RSN_ROOT] = exit_root_i & exit_smm_i;
		reason_new[vei_pkg::VEI_RSN_FAIL] = exit_entry_fail_i;
	end

	// Exit info for non-external vectored events; external ones get it only through acknowledge, with exit_ack_ctl_i set
	assign vec_record = exit_vectored_i && (exit_type_i != vei_pkg::VEI_TYP_EXT);
	always_comb
	begin
		info_new = 32'h0000_0000;
		if (vec_record)
		begin
			info_new[vei_pkg::VEI_INFO_VEC_MSB:vei_pkg::VEI_INFO_VEC_LSB] = exit_vector_i;
			info_new[vei_pkg::VEI_INFO_TYPE_MSB:vei_pkg::VEI_INFO_TYPE_LSB] = exit_type_i;
			info_new[vei_pkg::VEI_INFO_ERRV] = exit_errv_i;
			info_new[vei_pkg::VEI_INFO_UNBLOCK] = exit_unblock_i;
			info_new[vei_pkg::VEI_INFO_VALID] = 1'b1;
		end
	end

	// Exit information fields refuse every write
	assign fld_is_ro = (fld_sel_i == vei_pkg::VEI_FLD_EXIT_REASON) || (fld_sel_i == vei_pkg::VEI_FLD_EXIT_QUAL)
		|| (fld_sel_i == vei_pkg::VEI_FLD_EXIT_INFO) || (fld_sel_i == vei_pkg::VEI_FLD_EXIT_ERR);

	// Next-state logic
	always_comb
	begin
		r_nxt = r_r;
		r_nxt.msr_wr = 1'b0;
		r_nxt.inj_valid = 1'b0;
		r_nxt.done = 1'b0;
		r_nxt.fail = 1'b0;
		r_nxt.exit_done = 1'b0;
		r_nxt.fld_ack = 1'b0;
		r_nxt.fld_fail = 1'b0;
		ex.cap = 1'b0;
		ex.err_we = 1'b0;
		ex.reason = reason_new;
		ex.qual = exit_qual_i;
		ex.info = info_new;
		ex.err = exit_err_i;

		// Field read and write instructions, one cycle to answer
		if (fld_wr_i || fld_rd_i)
		begin
			r_nxt.fld_ack = 1'b1;
			r_nxt.fld_rdata = 64'h0000_0000_0000_0000;
			if (fld_wr_i)
			begin
				unique case (fld_sel_i)
					vei_pkg::VEI_FLD_LOAD_COUNT: r_nxt.cnt = fld_wdata_i[31:0];
					vei_pkg::VEI_FLD_LOAD_ADDR: r_nxt.addr = fld_wdata_i;
					vei_pkg::VEI_FLD_ENTRY_INFO: r_nxt.einfo = fld_wdata_i[31:0];
					vei_pkg::VEI_FLD_ENTRY_ERR: r_nxt.eerr = fld_wdata_i[31:0];
					vei_pkg::VEI_FLD_ENTRY_LEN: r_nxt.elen = fld_wdata_i[31:0];
					default: r_nxt.fld_fail = 1'b1;
				endcase
			end
			else
			begin
				unique case (fld_sel_i)
					vei_pkg::VEI_FLD_LOAD_COUNT: r_nxt.fld_rdata = {32'h0000_0000, r_r.cnt};
					vei_pkg::VEI_FLD_LOAD_ADDR: r_nxt.fld_rdata = r_r.addr;
					vei_pkg::VEI_FLD_ENTRY_INFO: r_nxt.fld_rdata = {32'h0000_0000, r_r.einfo};
					vei_pkg::VEI_FLD_ENTRY_ERR: r_nxt.fld_rdata = {32'h0000_0000, r_r.eerr};
					vei_pkg::VEI_FLD_ENTRY_LEN: r_nxt.fld_rdata = {32'h0000_0000, r_r.elen};
					vei_pkg::VEI_FLD_EXIT_REASON: r_nxt.fld_rdata = {32'h0000_0000, ex.reason_q};
					vei_pkg::VEI_FLD_EXIT_QUAL: r_nxt.fld_rdata = ex.qual_q;
					vei_pkg::VEI_FLD_EXIT_INFO: r_nxt.fld_rdata = {32'h0000_0000, ex.info_q};
					vei_pkg::VEI_FLD_EXIT_ERR: r_nxt.fld_rdata = {32'h0000_0000, ex.err_q};
					default: r_nxt.fld_fail = 1'b1;
				endcase
			end
			if (fld_wr_i && fld_is_ro)
			begin
				r_nxt.fld_fail = 1'b1;
			end
		end

		unique case (r_r.st)
			VEI_IDLE:
			begin
				// Exit takes priority over a same-cycle entry request
				if (exit_req_i)
				begin
					r_nxt.einfo[vei_pkg::VEI_INFO_VALID] = 1'b0;
					if (exit_vectored_i && (exit_type_i == vei_pkg::VEI_TYP_EXT) && exit_ack_ctl_i)
					begin
						r_nxt.hold_reason = reason_new;
						r_nxt.hold_qual = exit_qual_i;
						r_nxt.st = VEI_ACK;
					end
					else
					begin
						ex.cap = 1'b1;
						ex.err_we = vec_record && exit_errv_i && (exit_type_i == vei_pkg::VEI_TYP_HWEXC);
						r_nxt.exit_done = 1'b1;
					end
				end
				else if (entry_start_i)
				begin
					r_nxt.idx = 32'h0000_0000;
					if (r_r.cnt == 32'h0000_0000)
					begin
						r_nxt.st = VEI_INJECT;
					end
					else if ((r_r.addr[3:0] & vei_pkg::VEI_ALIGN_MASK) != 4'h0)
					begin
						// Misaligned area would fetch torn entries; refuse the entry
						r_nxt.fail = 1'b1;
					end
					else
					begin
						r_nxt.mem_req = 1'b1;
						r_nxt.mem_addr = r_r.addr;
						r_nxt.st = VEI_LOAD;
					end
				end
			end

			VEI_LOAD:
			begin
				// One entry per memory answer; the request stays up until taken
				if (mem_ack_i)
				begin
					r_nxt.msr_wr = 1'b1;
					r_nxt.msr_index = mem_rdata_i[vei_pkg::VEI_ENT_IDX_MSB:vei_pkg::VEI_ENT_IDX_LSB];
					r_nxt.msr_data = mem_rdata_i[vei_pkg::VEI_ENT_DATA_MSB:vei_pkg::VEI_ENT_DATA_LSB];
					r_nxt.idx = r_r.idx + 32'h0000_0001;
					if (r_r.idx + 32'h0000_0001 == r_r.cnt)
					begin
						r_nxt.mem_req = 1'b0;
						r_nxt.st = VEI_INJECT;
					end
					else
					begin
						r_nxt.mem_addr = r_r.addr + {28'h000_0000, r_nxt.idx, 4'h0};
					end
				end
			end

			VEI_INJECT:
			begin
				// Entered in the cycle the last register write is issued, or straight from idle when the load count is zero
				r_nxt.done = 1'b1;
				r_nxt.st = VEI_IDLE;
				if (ent_valid && ent_type_ok)
				begin
					r_nxt.inj_valid = 1'b1;
					r_nxt.inj_vec = r_r.einfo[vei_pkg::VEI_INFO_VEC_MSB:vei_pkg::VEI_INFO_VEC_LSB];
					r_nxt.inj_type = ent_type;
					r_nxt.inj_push = r_r.einfo[vei_pkg::VEI_INFO_ERRV];
					r_nxt.inj_err = r_r.einfo[vei_pkg::VEI_INFO_ERRV] ? r_r.eerr : 32'h0000_0000;
					r_nxt.inj_ip = ent_sw_type ? guest_ip_i + {32'h0000_0000, r_r.elen} : guest_ip_i;
				end
				else if (ent_valid)
				begin
					// Reserved type: refuse rather than deliver something undefined
					r_nxt.fail = 1'b1;
				end
			end

			VEI_ACK:
			begin
				// Wait for the interrupt controller to hand over the vector
				if (intack_ack_i)
				begin
					ex.cap = 1'b1;
					ex.reason = r_r.hold_reason;
					ex.qual = r_r.hold_qual;
					ex.info = 32'h0000_0000;
					ex.info[vei_pkg::VEI_INFO_VEC_MSB:vei_pkg::VEI_INFO_VEC_LSB] = intack_vector_i;
					ex.info[vei_pkg::VEI_INFO_TYPE_MSB:vei_pkg::VEI_INFO_TYPE_LSB] = vei_pkg::VEI_TYP_EXT;
					ex.info[vei_pkg::VEI_INFO_VALID] = 1'b1;
					r_nxt.exit_done = 1'b1;
					r_nxt.st = VEI_IDLE;
				end
			end

			default:
			begin
				r_nxt.st = VEI_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			r_r <= '{st: VEI_IDLE, cnt: vei_pkg::VEI_RST_COUNT, addr: vei_pkg::VEI_RST_ADDR,
				einfo: vei_pkg::VEI_RST_W32, eerr: vei_pkg::VEI_RST_W32, elen: vei_pkg::VEI_RST_W32,
				idx: vei_pkg::VEI_RST_W32, mem_req: 1'b0, mem_addr: vei_pkg::VEI_RST_ADDR,
				msr_wr: 1'b0, msr_index: vei_pkg::VEI_RST_W32, msr_data: vei_pkg::VEI_RST_QUAL,
				inj_valid: 1'b0, inj_vec: 8'h00, inj_type: 3'h0, inj_push: 1'b0,
				inj_err: vei_pkg::VEI_RST_W32, inj_ip: vei_pkg::VEI_RST_QUAL, done: 1'b0, fail: 1'b0,
				exit_done: 1'b0, hold_reason: vei_pkg::VEI_RST_W32, hold_qual: vei_pkg::VEI_RST_QUAL,
				fld_ack: 1'b0, fld_fail: 1'b0, fld_rdata: vei_pkg::VEI_RST_QUAL};
		end
		else
		begin
			r_r <= r_nxt;
		end
	end

	// Output drive, all from flip-flops except the ready handshakes and intack_req_o, decoded from the state (entry_ready_o also from exit_req_i)
	assign fld_ack_o = r_r.fld_ack;
	assign fld_fail_o = r_r.fld_fail;
	assign fld_rdata_o = r_r.fld_rdata;
	assign entry_ready_o = (r_r.st == VEI_IDLE) && !exit_req_i;
	assign exit_ready_o = (r_r.st == VEI_IDLE);
	assign entry_done_o = r_r.done;
	assign entry_fail_o = r_r.fail;
	assign mem_req_o = r_r.mem_req;
	assign mem_addr_o = r_r.mem_addr;
	assign msr_wr_o = r_r.msr_wr;
	assign msr_index_o = r_r.msr_index;
	assign msr_data_o = r_r.msr_data;
	assign inj_valid_o = r_r.inj_valid;
	assign inj_vector_o = r_r.inj_vec;
	assign inj_type_o = r_r.inj_type;
	assign inj_push_err_o = r_r.inj_push;
	assign inj_err_o = r_r.inj_err;
	assign inj_ip_o = r_r.inj_ip;
	assign exit_done_o = r_r.exit_done;
	assign intack_req_o = (r_r.st == VEI_ACK);

endmodule : vei_top

/* File: verilog/vei_pkg.sv */
package vei_pkg;

	// Field widths
	localparam int unsigned VEI_QUAL_W = 64;
	localparam int unsigned VEI_ADDR_W = 64;

	// Field selects of the field read and write instructions
	typedef enum logic [3:0] {
		VEI_FLD_LOAD_COUNT = 4'h0,
		VEI_FLD_LOAD_ADDR = 4'h1,
		VEI_FLD_ENTRY_INFO = 4'h2,
		VEI_FLD_ENTRY_ERR = 4'h3,
		VEI_FLD_ENTRY_LEN = 4'h4,
		VEI_FLD_EXIT_REASON = 4'h8,
		VEI_FLD_EXIT_QUAL = 4'h9,
		VEI_FLD_EXIT_INFO = 4'ha,
		VEI_FLD_EXIT_ERR = 4'hb
	} vei_fld_type;

	// Reset values of all fields
	localparam logic [31:0] VEI_RST_COUNT = 32'h0000_0000;
	localparam logic [63:0] VEI_RST_ADDR = 64'h0000_0000_0000_0000;
	localparam logic [31:0] VEI_RST_W32 = 32'h0000_0000;
	localparam logic [63:0] VEI_RST_QUAL = 64'h0000_0000_0000_0000;

	// Load-area entry layout
	localparam int unsigned VEI_ENT_IDX_LSB = 0;
	localparam int unsigned VEI_ENT_IDX_MSB = 31;
	localparam int unsigned VEI_ENT_DATA_LSB = 64;
	localparam int unsigned VEI_ENT_DATA_MSB = 127;
	localparam int unsigned VEI_ENT_SHIFT = 4;
	localparam logic [3:0] VEI_ALIGN_MASK = 4'hf;

	// Interruption-information field layout
	localparam int unsigned VEI_INFO_VEC_LSB = 0;
	localparam int unsigned VEI_INFO_VEC_MSB = 7;
	localparam int unsigned VEI_INFO_TYPE_LSB = 8;
	localparam int unsigned VEI_INFO_TYPE_MSB = 10;
	localparam int unsigned VEI_INFO_ERRV = 11;
	localparam int unsigned VEI_INFO_UNBLOCK = 12;
	localparam int unsigned VEI_INFO_VALID = 31;

	// Exit reason layout
	localparam int unsigned VEI_RSN_BASIC_MSB = 15;
	localparam int unsigned VEI_RSN_ROOT = 29;
	localparam int unsigned VEI_RSN_FAIL = 31;

	// Interruption types
	localparam logic [2:0] VEI_TYP_EXT = 3'h0;
	localparam logic [2:0] VEI_TYP_RSV1 = 3'h1;
	localparam logic [2:0] VEI_TYP_NMI = 3'h2;
	localparam logic [2:0] VEI_TYP_HWEXC = 3'h3;
	localparam logic [2:0] VEI_TYP_SWINT = 3'h4;
	localparam logic [2:0] VEI_TYP_PRIVSW = 3'h5;
	localparam logic [2:0] VEI_TYP_SWEXC = 3'h6;
	localparam logic [2:0] VEI_TYP_RSV7 = 3'h7;

endpackage : vei_pkg

/* File: verilog/vei_exit_if.sv */
`timescale 1ns/1ps
interface vei_exit_if;

	// Capture strobe and new field values
	logic cap;
	logic err_we;
	logic [31:0] reason;
	logic [63:0] qual;
	logic [31:0] info;
	logic [31:0] err;

	// Stored fields
	logic [31:0] reason_q;
	logic [63:0] qual_q;
	logic [31:0] info_q;
	logic [31:0] err_q;

	modport ctl (
		output cap, err_we, reason, qual, info, err,
		input reason_q, qual_q, info_q, err_q
	);

	modport rec (
		input cap, err_we, reason, qual, info, err,
		output reason_q, qual_q, info_q, err_q
	);

endinterface : vei_exit_if

/* File: verilog/vei_exit_rec.sv */
`timescale 1ns/1ps
module vei_exit_rec (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Capture side
	vei_exit_if.rec ex
);

	typedef struct packed {
		logic [31:0] reason;
		logic [63:0] qual;
		logic [31:0] info;
		logic [31:0] err;
	} vei_rec_type;

	vei_rec_type st_r;
	vei_rec_type st_nxt;

	// Fields change only on an exit; software has no write path here
	always_comb
	begin
		st_nxt = st_r;
		if (ex.cap)
		begin
			st_nxt.reason = ex.reason;
			st_nxt.qual = ex.qual;
			st_nxt.info = ex.info;
			if (ex.err_we)
			begin
				st_nxt.err = ex.err;
			end
		end
	end

	// State register
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st_r <= '{reason: vei_pkg::VEI_RST_W32, qual: vei_pkg::VEI_RST_QUAL,
				info: vei_pkg::VEI_RST_W32, err: vei_pkg::VEI_RST_W32};
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// Read-back of stored fields
	assign ex.reason_q = st_r.reason;
	assign ex.qual_q = st_r.qual;
	assign ex.info_q = st_r.info;
	assign ex.err_q = st_r.err;

endmodule : vei_exit_rec

/* File: bench/vei_top_asserts.sv */
`timescale 1ns/1ps
module vei_top_asserts (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Field access
	input wire logic fld_wr_i,
	input wire logic fld_rd_i,
	input wire logic [3:0] fld_sel_i,
	input wire logic fld_ack_o,
	input wire logic fld_fail_o,
	// Entry and load area
	input wire logic entry_done_o,
	input wire logic entry_ready_o,
	input wire logic mem_req_o,
	input wire logic [63:0] mem_addr_o,
	input wire logic mem_ack_i,
	input wire logic [127:0] mem_rdata_i,
	input wire logic msr_wr_o,
	input wire logic [31:0] msr_index_o,
	input wire logic [63:0] msr_data_o,
	// Injection
	input wire logic inj_valid_o,
	input wire logic [2:0] inj_type_o,
	input wire logic inj_push_err_o,
	input wire logic [31:0] inj_err_o,
	// Exit
	input wire logic exit_req_i,
	input wire logic exit_ready_o,
	input wire logic exit_done_o,
	input wire logic intack_req_o,
	input wire logic intack_ack_i
);
	logic [127:0] rd_r;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	// Memory word kept for pairing with the register write one cycle later
	always_ff @(posedge clk_i)
		rd_r <= mem_rdata_i;

	ack_timing_a: assert property (fld_ack_o == $past(fld_wr_i || fld_rd_i))
		else $error("field answer not one cycle after access");
	ro_write_a: assert property (fld_wr_i && fld_sel_i[3] |=> fld_ack_o && fld_fail_o)
		else $error("write to exit field not refused");
	msr_pair_a: assert property (msr_wr_o |-> $past(mem_ack_i) && msr_index_o == rd_r[31:0]
		&& msr_data_o == rd_r[127:64]) else $error("register write does not match load entry");
	req_hold_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
		else $error("load request dropped or moved before answer");
	load_align_a: assert property (mem_req_o |-> mem_addr_o[3:0] == 4'h0)
		else $error("load address not 16-byte aligned");
	inj_last_a: assert property (inj_valid_o |-> entry_done_o && !mem_req_o)
		else $error("injection not at end of entry");
	inj_type_a: assert property (inj_valid_o |-> !(inj_type_o inside {3'h1, 3'h7}))
		else $error("reserved type injected");
	err_gate_a: assert property (inj_valid_o && !inj_push_err_o |-> inj_err_o == 32'h0)
		else $error("error code used without push");
	intack_hold_a: assert property (intack_req_o && !intack_ack_i |=> intack_req_o)
		else $error("acknowledge request dropped early");
	intack_done_a: assert property (intack_req_o && intack_ack_i |=> exit_done_o)
		else $error("exit not done after acknowledge");
	exit_time_a: assert property (exit_req_i && exit_ready_o |-> ##[1:40] exit_done_o)
		else $error("exit not completed in time");
	ready_busy_a: assert property ((mem_req_o || intack_req_o) |-> !entry_ready_o && !exit_ready_o)
		else $error("ready shown while busy");

	// Main scenarios reached
	inj_c: cover property (inj_valid_o);
	msr_c: cover property (msr_wr_o);
	intack_c: cover property (intack_req_o && intack_ack_i);
	fail_c: cover property (fld_ack_o && fld_fail_o);
endmodule : vei_top_asserts

bind vei_top vei_top_asserts u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .fld_wr_i(fld_wr_i),
	.fld_rd_i(fld_rd_i), .fld_sel_i(fld_sel_i), .fld_ack_o(fld_ack_o), .fld_fail_o(fld_fail_o),
	.entry_done_o(entry_done_o), .entry_ready_o(entry_ready_o), .mem_req_o(mem_req_o),
	.mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i),
	.mem_rdata_i(mem_rdata_i), .msr_wr_o(msr_wr_o), .msr_index_o(msr_index_o), .msr_data_o(msr_data_o),
	.inj_valid_o(inj_valid_o), .inj_type_o(inj_type_o), .inj_push_err_o(inj_push_err_o),
	.inj_err_o(inj_err_o), .exit_req_i(exit_req_i), .exit_ready_o(exit_ready_o),
	.exit_done_o(exit_done_o), .intack_req_o(intack_req_o), .intack_ack_i(intack_ack_i));

/* File: bench/test_vei_top.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_vei_top;
	// Design ports
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic fld_wr_i = 1'b0, fld_rd_i = 1'b0, entry_start_i = 1'b0, mem_ack_i = 1'b0, exit_req_i = 1'b0;
	logic [3:0] fld_sel_i = 4'h0;
	logic [63:0] fld_wdata_i = 64'h0, guest_ip_i = 64'h0, exit_qual_i = 64'h0;
	logic [127:0] mem_rdata_i = 128'h0;
	logic [15:0] exit_basic_i = 16'h0;
	logic [2:0] exit_type_i = 3'h0;
	logic [7:0] exit_vector_i = 8'h0, intack_vector_i = 8'h0;
	logic [31:0] exit_err_i = 32'h0;
	logic exit_entry_fail_i = 1'b0, exit_root_i = 1'b0, exit_smm_i = 1'b0, exit_vectored_i = 1'b0;
	logic exit_errv_i = 1'b0, exit_unblock_i = 1'b0, exit_ack_ctl_i = 1'b0, intack_ack_i = 1'b0;
	logic [63:0] fld_rdata_o, mem_addr_o, msr_data_o, inj_ip_o;
	logic [31:0] msr_index_o, inj_err_o;
	logic [7:0] inj_vector_o;
	logic [2:0] inj_type_o;
	logic fld_ack_o, fld_fail_o, entry_ready_o, entry_done_o, entry_fail_o, mem_req_o, msr_wr_o;
	logic inj_valid_o, inj_push_err_o, exit_ready_o, exit_done_o, intack_req_o;
	// Bench state
	int bad_count = 0;
	int cmp_count = 0;
	int mwait = 0;
	logic [127:0] expq[$];
	logic [63:0] fm[16];
	logic [2:0] tt[4] = '{3'h0, 3'h2, 3'h3, 3'h6};

	vei_top uut (.*);

	// Free-running clock
	always #20 clk_i = ~clk_i;

	// Load-area contents derived from the address
	function automatic logic [127:0] ent(input logic [63:0] a);
		ent = {a ^ 64'h5a5a_0f0f_c3c3_9696, ~a[31:0], a[35:4] ^ 32'h0000_0c00};
	endfunction : ent

	task automatic close_out;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out

	// Memory with random wait states; data inverted outside answers so stale words never match
	always @(posedge clk_i)
	begin
		mem_ack_i <= 1'b0;
		mem_rdata_i <= ~mem_rdata_i;
		if (mem_req_o && !mem_ack_i && mwait == 0)
		begin
			mem_ack_i <= 1'b1;
			mem_rdata_i <= ent(mem_addr_o);
			mwait = $urandom % 3;
		end
		else if (mwait > 0)
			mwait--;
	end

	// Interrupt controller answers one cycle after request
	always @(posedge clk_i)
		intack_ack_i <= intack_req_o && !intack_ack_i;

	task automatic take(input logic [127:0] got);
		logic [127:0] e;
		// An output with nothing expected is a mismatch on its own, whatever it carries
		if (expq.size() == 0)
			`CHK(1'b0, 1'b1)
		else
		begin
			e = expq.pop_front();
			`CHK(got, e)
		end
	endtask : take

	// Output watcher; events in one cycle are taken in a fixed order
	always @(posedge clk_i)
		if (rst_n_i)
		begin
			if (fld_ack_o)
				take({32'h1, 31'h0, fld_fail_o, fld_rdata_o});
			if (msr_wr_o)
				take({32'h2, msr_index_o, msr_data_o});
			if (inj_valid_o)
				take({20'h3, inj_vector_o, inj_type_o, inj_push_err_o, inj_err_o, inj_ip_o});
			if (entry_done_o || entry_fail_o)
				take({32'h4, 94'h0, entry_done_o, entry_fail_o});
			if (exit_done_o)
				take({32'h5, 96'h0});
		end

	task automatic drain;
		int n = 0;
		while (expq.size() != 0 && n < 200)
		begin
			@(posedge clk_i);
			n++;
		end
		if (n == 200)
		begin
			bad_count++;
			close_out;
		end
		@(posedge clk_i);
	endtask : drain

	task automatic fld(input logic wr, input logic [3:0] sel, input logic [63:0] d);
		logic bad;
		// Writes fail above the entry fields; reads fail only on unused selects
		bad = wr ? (sel > 4'h4) : ((sel inside {4'h5, 4'h6, 4'h7}) || sel > 4'hb);
		if (wr && !bad)
			fm[sel] = (sel == 4'h1) ? d : {32'h0, d[31:0]};
		expq.push_back({32'h1, 31'h0, bad, wr ? 64'h0 : fm[sel]});
		@(posedge clk_i);
		fld_wr_i <= wr;
		fld_rd_i <= !wr;
		fld_sel_i <= sel;
		fld_wdata_i <= d;
		@(posedge clk_i);
		fld_wr_i <= 1'b0;
		fld_rd_i <= 1'b0;
		drain;
	endtask : fld

	task automatic entry(input int n, input logic [63:0] base, input logic [31:0] info);
		logic [63:0] gip;
		logic [127:0] e;
		logic [2:0] t;
		gip = {$urandom, $urandom};
		t = info[10:8];
		// Hardware exceptions keep one ordinary vector; the software-exception cases stay apart
		if (t == 3'h3)
			info[7:0] = 8'h0d;
		fld(1'b1, 4'h0, 64'(n));
		fld(1'b1, 4'h1, base);
		fld(1'b1, 4'h2, {$urandom, info});
		fld(1'b1, 4'h3, {$urandom, $urandom});
		fld(1'b1, 4'h4, {$urandom, 32'($urandom % 16)});
		guest_ip_i <= gip;
		if (n != 0 && base[3:0] != 4'h0)
			expq.push_back({32'h4, 96'h1});
		else
		begin
			for (int i = 0; i < n; i++)
			begin
				e = ent(base + 64'(16 * i));
				expq.push_back({32'h2, e[31:0], e[127:64]});
			end
			if (info[31] && (t == 3'h1 || t == 3'h7))
				expq.push_back({32'h4, 96'h3});
			else
			begin
				if (info[31])
					expq.push_back({20'h3, info[7:0], t, info[11], info[11] ? fm[3][31:0] : 32'h0,
						gip + ((t inside {3'h4, 3'h5, 3'h6}) ? fm[4] : 64'h0)});
				expq.push_back({32'h4, 96'h2});
			end
		end
		@(posedge clk_i);
		entry_start_i <= 1'b1;
		@(posedge clk_i);
		entry_start_i <= 1'b0;
		drain;
	endtask : entry

	task automatic vexit(input logic [2:0] t, input logic vect, input logic ackc);
		logic [31:0] b, er, inf;
		logic [63:0] q;
		logic [7:0] v, iv;
		logic f, r, s, ev, un;
		{b, er} = {$urandom, $urandom};
		q = {$urandom, $urandom};
		{v, iv, f, r, s, ev, un} = 21'($urandom);
		ev = ev && vect;
		// Acknowledged external interrupts carry only vector, type and valid
		inf = (vect && (t != 3'h0 || ackc)) ? {1'b1, 18'h0, un && t != 3'h0, ev && t != 3'h0, t,
			(t == 3'h0) ? iv : v} : 32'h0;
		fm[8] = {32'h0, f, 1'b0, r && s, 13'h0, b[15:0]};
		fm[9] = q;
		fm[10] = {32'h0, inf};
		fm[2][31] = 1'b0;
		if (vect && t == 3'h3 && ev)
			fm[11] = {32'h0, er};
		expq.push_back({32'h5, 96'h0});
		@(posedge clk_i);
		{exit_req_i, exit_basic_i, exit_entry_fail_i, exit_root_i, exit_smm_i} <= {1'b1, b[15:0], f, r, s};
		{exit_qual_i, exit_vectored_i, exit_type_i, exit_vector_i} <= {q, vect, t, v};
		{exit_errv_i, exit_err_i, exit_unblock_i, exit_ack_ctl_i, intack_vector_i} <= {ev, er, un, ackc, iv};
		@(posedge clk_i);
		exit_req_i <= 1'b0;
		drain;
		for (int k = 8; k < 12; k++)
			fld(1'b0, 4'(k), 64'h0);
		fld(1'b0, 4'h2, 64'h0);
	endtask : vexit

	// Main sequence
	initial
	begin
		void'($urandom(32'hdcff));
		foreach (fm[k])
			fm[k] = 64'h0;
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'b1;
		for (int k = 0; k < 16; k++)
			fld(1'b0, 4'(k), 64'h0);
		for (int k = 5; k < 16; k++)
			fld(1'b1, 4'(k), {$urandom, $urandom});
		for (int t = 0; t < 8; t++)
			entry(t % 3, {$urandom, $urandom} & ~64'hf, {1'b1, 19'h0, 1'($urandom), 3'(t), 8'($urandom)});
		entry(2, {$urandom, $urandom} & ~64'hf, {1'b0, 19'h0, 1'b1, 3'h3, 8'h0e});
		entry(1, {$urandom, $urandom} | 64'h8, {1'b1, 19'h0, 1'b1, 3'h3, 8'h0d});
		for (int k = 0; k < 12; k++)
			vexit(tt[k % 4], k != 11, k < 8);
		close_out;
	end

	// Watchdog well beyond the expected run length
	initial
	begin
		repeat (20000) @(posedge clk_i);
		bad_count++;
		close_out;
	end
endmodule : test_vei_top
